// ---- hw/mdo_pkg.sv ----
/*
  Constants for the mute-dependent override controller: register map, field
  positions, reset values, modes, states and timing figures.
  Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package mdo_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int OPEN_MAX_MS = 1000;
  localparam int OVR_MAX_S = 120;
  localparam int OVR_MAX_MS = OVR_MAX_S * 1000;
  localparam int PULSES_NEEDED = 3;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_ELAPSED = 8'h10;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_UNIDIR = 2;
  localparam int CTRL_AUTORESTART = 3;
  localparam int CTRL_ENABLE = 4;
  localparam int CTRL_RESTART = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0018;

  localparam int IRQ_START = 0;
  localparam int IRQ_END = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_ZONESTOP = 3;
  localparam int IRQ_BITS = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_LEVEL = 2'b01,
    MODE_EDGE = 2'b10
  } mdo_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPEN = 2'b01,
    ST_CLOSED = 2'b10,
    ST_OVERRIDE = 2'b11
  } mdo_state_type;

endpackage

// ---- hw/mdo_override.sv ----
/*
  Mute-dependent override controller with AXI4-Lite register access.
  Assumes switch, mute sensor and zone inputs arrive asynchronously from pins
  and that one 25 MHz clock drives all logic.
*/
`timescale 1ns/1ps
`default_nettype none
module mdo_override #(
  parameter int NUM_MUTE = 4,
  parameter bit TWO_INPUTS = 1'b1,
  parameter int TICK_CYCLES = mdo_pkg::TICK_CYCLES,
  parameter int OPEN_LIMIT_TICKS = mdo_pkg::OPEN_MAX_MS,
  parameter int OVR_LIMIT_TICKS = mdo_pkg::OVR_MAX_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Field pins
  input wire logic overrideIn1,
  input wire logic overrideIn2,
  input wire logic [NUM_MUTE-1:0] muteSensor,
  input wire logic zoneIntruded,
  input wire logic otherAreaIntruded,
  // Field outputs and indicators
  output logic safetyOutput,
  output logic overrideDisplay,
  output logic lampGreen,
  output logic irq,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int SW = NUM_MUTE + 4;
  logic [SW-1:0] syncA_ff;
  logic [SW-1:0] syncB_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Second override input idles closed; resetting it high avoids a false edge
      syncA_ff <= {{(SW-2){1'b0}}, 2'b10};
      syncB_ff <= {{(SW-2){1'b0}}, 2'b10};
    end else begin
      syncA_ff <= {otherAreaIntruded, zoneIntruded, muteSensor, overrideIn2, overrideIn1};
      syncB_ff <= syncA_ff;
    end
  end
  logic sw1, sw2, zoneHit, otherHit, anyMute;
  assign sw1 = syncB_ff[0];
  assign sw2 = syncB_ff[1];
  assign anyMute = |syncB_ff[NUM_MUTE+1:2];
  assign zoneHit = syncB_ff[NUM_MUTE+2];
  assign otherHit = syncB_ff[NUM_MUTE+3];

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  logic [31:0] divCnt_ff;
  logic tick_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else if (divCnt_ff == 32'(TICK_CYCLES - 1)) begin
      divCnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b1;
    end else begin
      divCnt_ff <= divCnt_ff + 32'h0000_0001;
      tick_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  localparam int IRQ_W = mdo_pkg::IRQ_BITS;
  logic [31:0] ctrl_ff;
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqMask_ff;
  mdo_pkg::mdo_mode_type mode;
  logic uniDir, autoRestart, enabled;

  // Mode 3 and two-input modes on a single-input unit fall back to single-line
  always_comb begin
    if (TWO_INPUTS && ctrl_ff[mdo_pkg::CTRL_MODE_LSB +: 2] == mdo_pkg::MODE_LEVEL) begin
      mode = mdo_pkg::MODE_LEVEL;
    end else if (TWO_INPUTS && ctrl_ff[mdo_pkg::CTRL_MODE_LSB +: 2] == mdo_pkg::MODE_EDGE) begin
      mode = mdo_pkg::MODE_EDGE;
    end else begin
      mode = mdo_pkg::MODE_SINGLE;
    end
  end
  assign uniDir = ctrl_ff[mdo_pkg::CTRL_UNIDIR];
  assign autoRestart = ctrl_ff[mdo_pkg::CTRL_AUTORESTART];
  assign enabled = ctrl_ff[mdo_pkg::CTRL_ENABLE];

  // ------------------------------------------------------------
  // Override sequencer
  // ------------------------------------------------------------
  mdo_pkg::mdo_state_type state_ff;
  logic [31:0] tmr_ff;
  logic [1:0] pulses_ff;
  logic armed_ff;
  logic edge1_ff, edge2_ff;
  logic sw1Prev_ff, sw2Prev_ff;
  logic safeOut_ff;
  logic restartReq;
  logic away1, away2, bothIdle, canStart, accept, stopOvr, timeout;

  assign away1 = sw1;
  assign away2 = !sw2;
  // Single-line idle is the closed switch, two-input idle is first low, second high
  assign bothIdle = (mode == mdo_pkg::MODE_SINGLE) ? sw1 : (!sw1 && sw2);
  assign canStart = enabled && zoneHit && !safeOut_ff && anyMute;
  assign timeout = tmr_ff >= 32'(OVR_LIMIT_TICKS);

  always_comb begin
    accept = 1'b0;
    if (canStart && armed_ff) begin
      case (mode)
        mdo_pkg::MODE_SINGLE: accept = (state_ff == mdo_pkg::ST_OPEN) && sw1 &&
                                       (pulses_ff == 2'(mdo_pkg::PULSES_NEEDED - 1));
        mdo_pkg::MODE_LEVEL: accept = away1 && away2 && state_ff == mdo_pkg::ST_CLOSED;
        mdo_pkg::MODE_EDGE: accept = edge1_ff && edge2_ff;
        default: accept = 1'b0;
      endcase
    end
  end

  always_comb begin
    stopOvr = timeout;
    if (uniDir) begin
      if (!anyMute && !zoneHit) stopOvr = 1'b1;
    end else begin
      if (!zoneHit) stopOvr = 1'b1;
      if (!anyMute) stopOvr = 1'b1;
    end
    if (mode == mdo_pkg::MODE_LEVEL && (!away1 || !away2)) stopOvr = 1'b1;
    if (!enabled) stopOvr = 1'b1;
  end

  // Re-arm only after the switches have been seen at idle, so a stuck switch cannot retrigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_ff <= 1'b0;
    end else if (state_ff == mdo_pkg::ST_OVERRIDE || accept) begin
      armed_ff <= 1'b0;
    end else if (bothIdle) begin
      armed_ff <= 1'b1;
    end
  end

  // Edge capture for edge-triggered mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw1Prev_ff <= 1'b0;
      sw2Prev_ff <= 1'b1;
      edge1_ff <= 1'b0;
      edge2_ff <= 1'b0;
    end else begin
      sw1Prev_ff <= sw1;
      sw2Prev_ff <= sw2;
      if (mode != mdo_pkg::MODE_EDGE || state_ff == mdo_pkg::ST_OVERRIDE || !canStart) begin
        edge1_ff <= 1'b0;
        edge2_ff <= 1'b0;
      end else begin
        if (sw1 && !sw1Prev_ff && armed_ff) edge1_ff <= 1'b1;
        if (!sw2 && sw2Prev_ff && armed_ff) edge2_ff <= 1'b1;
      end
    end
  end

  // Main state machine; ST_OPEN/ST_CLOSED track the single-line pulse train
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= mdo_pkg::ST_IDLE;
      tmr_ff <= 32'h0000_0000;
      pulses_ff <= 2'b00;
    end else begin
      case (state_ff)
        mdo_pkg::ST_IDLE: begin
          tmr_ff <= 32'h0000_0000;
          pulses_ff <= 2'b00;
          if (accept) begin
            state_ff <= mdo_pkg::ST_OVERRIDE;
          end else if (canStart && armed_ff && mode == mdo_pkg::MODE_SINGLE &&
                       sw1Prev_ff && !sw1) begin
            // Only a fresh opening counts, so an over-long open cannot restart the count
            state_ff <= mdo_pkg::ST_OPEN;
          end else if (canStart && armed_ff && mode == mdo_pkg::MODE_LEVEL && away1 && away2) begin
            state_ff <= mdo_pkg::ST_CLOSED;
          end
        end
        mdo_pkg::ST_OPEN: begin
          if (tick_ff) tmr_ff <= tmr_ff + 32'h0000_0001;
          if (accept) begin
            state_ff <= mdo_pkg::ST_OVERRIDE;
            tmr_ff <= 32'h0000_0000;
          end else if (!canStart || tmr_ff >= 32'(OPEN_LIMIT_TICKS)) begin
            state_ff <= mdo_pkg::ST_IDLE;
          end else if (sw1) begin
            state_ff <= mdo_pkg::ST_CLOSED;
            pulses_ff <= pulses_ff + 2'b01;
            tmr_ff <= 32'h0000_0000;
          end
        end
        mdo_pkg::ST_CLOSED: begin
          if (tick_ff) tmr_ff <= tmr_ff + 32'h0000_0001;
          if (accept) begin
            state_ff <= mdo_pkg::ST_OVERRIDE;
            tmr_ff <= 32'h0000_0000;
          end else if (!canStart || mode == mdo_pkg::MODE_LEVEL) begin
            state_ff <= mdo_pkg::ST_IDLE;
          end else if (tmr_ff >= 32'(OPEN_LIMIT_TICKS)) begin
            state_ff <= mdo_pkg::ST_IDLE;
          end else if (!sw1) begin
            state_ff <= mdo_pkg::ST_OPEN;
            tmr_ff <= 32'h0000_0000;
          end
        end
        mdo_pkg::ST_OVERRIDE: begin
          if (tick_ff) tmr_ff <= tmr_ff + 32'h0000_0001;
          if (stopOvr) begin
            state_ff <= mdo_pkg::ST_IDLE;
          end
        end
        default: state_ff <= mdo_pkg::ST_IDLE;
      endcase
    end
  end

  // Safety output: other-area intrusion always wins over the override
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      safeOut_ff <= 1'b0;
    end else if (otherHit) begin
      safeOut_ff <= 1'b0;
    end else if (state_ff == mdo_pkg::ST_OVERRIDE && !stopOvr) begin
      safeOut_ff <= 1'b1;
    end else if (zoneHit) begin
      safeOut_ff <= 1'b0;
    end else if (autoRestart || restartReq) begin
      safeOut_ff <= 1'b1;
    end
  end

  // Indicators
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      safetyOutput <= 1'b0;
      overrideDisplay <= 1'b0;
      lampGreen <= 1'b0;
      irq <= 1'b0;
    end else begin
      safetyOutput <= safeOut_ff;
      overrideDisplay <= state_ff == mdo_pkg::ST_OVERRIDE;
      lampGreen <= safeOut_ff;
      irq <= |(irqStat_ff & irqMask_ff);
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic haveAw_ff, haveW_ff, doWrite;
  logic [IRQ_W-1:0] events, w1c;
  logic ovrPrev_ff;

  assign doWrite = haveAw_ff && haveW_ff && !s_axi_bvalid;
  assign restartReq = doWrite && awAddr_ff == mdo_pkg::ADDR_CTRL && wStrb_ff[0] &&
                      wData_ff[mdo_pkg::CTRL_RESTART];
  assign w1c = (doWrite && awAddr_ff == mdo_pkg::ADDR_IRQ_STAT && wStrb_ff[0]) ?
               wData_ff[IRQ_W-1:0] : '0;
  assign events = {otherHit && safeOut_ff,
                   state_ff == mdo_pkg::ST_OVERRIDE && timeout,
                   ovrPrev_ff && state_ff != mdo_pkg::ST_OVERRIDE,
                   !ovrPrev_ff && state_ff == mdo_pkg::ST_OVERRIDE};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      haveAw_ff <= 1'b0;
      haveW_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mdo_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !haveAw_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !haveW_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        haveAw_ff <= 1'b0;
        haveW_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_ff[1:0] == 2'b00 && awAddr_ff <= mdo_pkg::ADDR_ELAPSED) ?
                       mdo_pkg::RESP_OKAY : mdo_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; restart bit is a pulse and is not stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= mdo_pkg::CTRL_RESET;
      irqMask_ff <= '0;
    end else if (doWrite && wStrb_ff[0]) begin
      if (awAddr_ff == mdo_pkg::ADDR_CTRL) ctrl_ff <= {27'h000_0000, wData_ff[4:0]};
      if (awAddr_ff == mdo_pkg::ADDR_IRQ_MASK) irqMask_ff <= wData_ff[IRQ_W-1:0];
    end
  end

  // Sticky status, a new event beats a simultaneous clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_ff <= '0;
      ovrPrev_ff <= 1'b0;
    end else begin
      ovrPrev_ff <= state_ff == mdo_pkg::ST_OVERRIDE;
      irqStat_ff <= (irqStat_ff & ~w1c) | events;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mdo_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mdo_pkg::RESP_OKAY;
        case (s_axi_araddr)
          mdo_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_ff;
          mdo_pkg::ADDR_STATUS: s_axi_rdata <= {20'h0_0000, anyMute, zoneHit, otherHit, sw2,
                                                sw1, armed_ff, pulses_ff, safeOut_ff,
                                                state_ff == mdo_pkg::ST_OVERRIDE, state_ff};
          mdo_pkg::ADDR_IRQ_STAT: s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irqStat_ff};
          mdo_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {{(32-IRQ_W){1'b0}}, irqMask_ff};
          mdo_pkg::ADDR_ELAPSED: s_axi_rdata <= tmr_ff;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mdo_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- testbench/mdo_override_props.sv ----
/*
  Pin-level checks on the override controller, bound to its top module.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mdo_override_props #(
  parameter int NUM_MUTE = 4,
  parameter int TICK_CYCLES = 10,
  parameter int OVR_LIMIT_TICKS = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Field pins
  input wire logic overrideIn1,
  input wire logic overrideIn2,
  input wire logic [NUM_MUTE-1:0] muteSensor,
  input wire logic zoneIntruded,
  input wire logic otherAreaIntruded,
  // Outputs and write-response handshake
  input wire logic safetyOutput,
  input wire logic overrideDisplay,
  input wire logic lampGreen,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Slack covers the tick prescaler phase and the input synchronisers
  localparam int LIMIT = (OVR_LIMIT_TICKS + 2) * TICK_CYCLES + 8;
  int ovrCycles_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ovrCycles_ff <= 0;
    else ovrCycles_ff <= overrideDisplay ? ovrCycles_ff + 1 : 0;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_start_mute;
    !(|muteSensor) [*6] |-> !$rose(overrideDisplay);
  endproperty
  a_start_mute: assert property (p_start_mute) else $error("override began without mute");
  property p_start_zone;
    !zoneIntruded [*6] |-> !$rose(overrideDisplay);
  endproperty
  a_start_zone: assert property (p_start_zone) else $error("override began, zone clear");
  property p_start_off;
    $rose(overrideDisplay) |-> !$past(safetyOutput);
  endproperty
  a_start_off: assert property (p_start_off) else $error("override began, output on");
  property p_no_auto;
    (overrideIn1 && overrideIn2) [*8] |-> !$rose(overrideDisplay);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("override began, switches idle");
  property p_other_drop;
    otherAreaIntruded [*5] |-> !safetyOutput;
  endproperty
  a_other_drop: assert property (p_other_drop) else $error("output on, other area hit");
  property p_ovr_on;
    (overrideDisplay && !otherAreaIntruded) [*5] |-> safetyOutput;
  endproperty
  a_ovr_on: assert property (p_ovr_on) else $error("output off during override");
  property p_limit;
    ovrCycles_ff <= LIMIT;
  endproperty
  a_limit: assert property (p_limit) else $error("override ran past its limit");
  property p_end_clear;
    (!zoneIntruded && !(|muteSensor)) [*6] |-> !overrideDisplay;
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("override kept, all clear");
  property p_lamp;
    $rose(overrideDisplay) |-> ##[0:2] lampGreen;
  endproperty
  a_lamp: assert property (p_lamp) else $error("green lamp missing on override");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
endmodule
bind mdo_override mdo_override_props #(.NUM_MUTE(NUM_MUTE), .TICK_CYCLES(TICK_CYCLES),
  .OVR_LIMIT_TICKS(OVR_LIMIT_TICKS)) props (.clk(clk), .reset_n(reset_n),
  .overrideIn1(overrideIn1), .overrideIn2(overrideIn2), .muteSensor(muteSensor),
  .zoneIntruded(zoneIntruded), .otherAreaIntruded(otherAreaIntruded),
  .safetyOutput(safetyOutput), .overrideDisplay(overrideDisplay), .lampGreen(lampGreen),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// ---- testbench/mdo_field_model.sv ----
/*
  Field model: operator override switches, mute sensors and zone pins.
  Assumes its tasks are called from the bench on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mdo_field_model (
  // Clock
  input wire logic clk,
  // Field pins
  output logic in1,
  output logic in2,
  output logic [3:0] mute,
  output logic zone,
  output logic other
);
  initial begin
    in1 = 1'b1; // Normally closed single-line switch idles high
    in2 = 1'b1; // Second input idles closed
    mute = 4'h0;
    zone = 1'b0;
    other = 1'b0;
  end
  task automatic env(input logic [3:0] m, input logic z, input logic o);
    @(posedge clk);
    mute <= m;
    zone <= z;
    other <= o;
  endtask
  // Open then reclose n times; spans in cycles, slow or prompt
  task automatic pulses(input int n, input int openC, input int gapC);
    repeat (n) begin
      @(posedge clk);
      in1 <= 1'b0;
      repeat (openC) @(posedge clk);
      in1 <= 1'b1;
      repeat (gapC) @(posedge clk);
    end
  endtask
  // Two-input levels; idle is a=0, b=1, request is both moved away
  task automatic sw(input logic a, input logic b);
    @(posedge clk);
    in1 <= a;
    in2 <= b;
  endtask
endmodule
`default_nettype wire

// ---- testbench/mdo_override_test.sv ----
/*
  Self-checking bench for the override controller: bus tasks plus field
  sequences in single-line, level, edge and unidirectional setups.
  Assumes the field model owns every switch, mute and zone pin.
*/
`timescale 1ns/1ps
`default_nettype none
module mdo_override_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic in1, in2, zone, other, safetyOutput, overrideDisplay, lampGreen, irq;
  logic [3:0] mute;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
  logic [31:0] wData = 32'h0000_0000, rData;
  logic [1:0] bResp, rResp;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid;
  int nErrors = 0;
  int testsRun = 0;
  always #20 clk = ~clk;
  // Short counts keep the run brief: tick 10 cycles, open 200, override 500
  mdo_override #(.TICK_CYCLES(10), .OPEN_LIMIT_TICKS(20), .OVR_LIMIT_TICKS(50)) uut (
    .clk(clk), .reset_n(reset_n), .overrideIn1(in1), .overrideIn2(in2), .muteSensor(mute),
    .zoneIntruded(zone), .otherAreaIntruded(other), .safetyOutput(safetyOutput),
    .overrideDisplay(overrideDisplay), .lampGreen(lampGreen), .irq(irq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  mdo_field_model f (.clk(clk), .in1(in1), .in2(in2), .mute(mute), .zone(zone), .other(other));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic outs(input logic [2:0] e);
    chk("outputs", 32'(e), 32'({safetyOutput, overrideDisplay, lampGreen}));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid && t < 50);
    chk("bvalid", 32'h0000_0001, 32'(bValid));
    chk("bresp", 32'h0000_0000, 32'(bResp));
    bReady <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arReady) arValid <= 1'b0;
    end while (!rValid && t < 50);
    chk("rvalid", 32'h0000_0001, 32'(rValid));
    chk(n, e, rData);
    chk("rresp", 32'(er), 32'(rResp));
    rReady <= 1'b0;
  endtask
  task automatic wrapUp();
    if (nErrors == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    cyc(12);
    reset_n <= 1'b1;
    cyc(8);
    rc("ctrl", mdo_pkg::ADDR_CTRL, mdo_pkg::CTRL_RESET, 2'b00);
    outs(3'b101);
    rc("unmapped", 8'h40, 32'h0000_0000, mdo_pkg::RESP_SLVERR);
    wr(mdo_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
    f.env(4'h1, 1'b1, 1'b0);
    cyc(8);
    outs(3'b000);
    f.pulses(2, 50, 50);
    cyc(8);
    outs(3'b000);
    cyc(300);
    f.pulses(1, 300, 50);
    f.pulses(2, 50, 50);
    outs(3'b000);
    f.env(4'h0, 1'b1, 1'b0);
    f.pulses(3, 50, 50);
    outs(3'b000);
    f.env(4'h1, 1'b1, 1'b0);
    f.pulses(3, 50, 50);
    outs(3'b111);
    chk("irq", 32'h0000_0001, 32'(irq));
    f.pulses(1, 50, 50);
    outs(3'b111);
    f.env(4'h1, 1'b1, 1'b1);
    cyc(8);
    outs(3'b010);
    f.env(4'h1, 1'b1, 1'b0);
    cyc(8);
    outs(3'b111);
    f.env(4'h1, 1'b0, 1'b0);
    cyc(8);
    outs(3'b101);
    rc("irqStat", mdo_pkg::ADDR_IRQ_STAT, 32'h0000_000B, 2'b00);
    wr(mdo_pkg::ADDR_IRQ_STAT, 32'h0000_000F);
    cyc(4);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(mdo_pkg::ADDR_CTRL, 32'h0000_0019);
    f.sw(1'b0, 1'b1);
    f.env(4'h1, 1'b1, 1'b0);
    cyc(8);
    f.sw(1'b1, 1'b0);
    cyc(8);
    outs(3'b111);
    f.sw(1'b1, 1'b1);
    cyc(8);
    outs(3'b000);
    wr(mdo_pkg::ADDR_CTRL, 32'h0000_001A);
    f.sw(1'b0, 1'b1);
    cyc(8);
    f.sw(1'b1, 1'b0);
    cyc(8);
    outs(3'b111);
    f.sw(1'b0, 1'b1);
    cyc(8);
    outs(3'b111);
    f.env(4'h0, 1'b1, 1'b0);
    cyc(8);
    outs(3'b000);
    wr(mdo_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
    f.env(4'h1, 1'b1, 1'b0);
    cyc(8);
    f.sw(1'b1, 1'b0);
    cyc(475);
    outs(3'b111);
    chk("irq", 32'h0000_0000, 32'(irq));
    cyc(50);
    outs(3'b000);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(mdo_pkg::ADDR_CTRL, 32'h0000_001E);
    f.sw(1'b0, 1'b1);
    cyc(8);
    f.sw(1'b1, 1'b0);
    cyc(8);
    outs(3'b111);
    f.env(4'h0, 1'b1, 1'b0);
    cyc(8);
    outs(3'b111);
    f.env(4'h0, 1'b0, 1'b0);
    cyc(8);
    outs(3'b101);
    wr(mdo_pkg::ADDR_CTRL, 32'h0000_0010);
    f.env(4'h0, 1'b1, 1'b0);
    cyc(8);
    outs(3'b000);
    f.env(4'h0, 1'b0, 1'b0);
    cyc(8);
    outs(3'b000);
    wr(mdo_pkg::ADDR_CTRL, 32'h0000_0030);
    cyc(4);
    outs(3'b101);
    rc("ctrl", mdo_pkg::ADDR_CTRL, 32'h0000_0010, 2'b00);
    wrapUp();
  end
  // Watchdog: the sequence needs about 2500 cycles
  initial begin
    cyc(20000);
    nErrors++;
    wrapUp();
  end
endmodule
`default_nettype wire
